/* File: fan_monitor_config_pkg.sv */
// Package for the fan monitor configuration register group.
// Assumes one 8-bit register port on mclk and a reading link on its own clock.
package fan_monitor_config_pkg;

	// Register offsets
	localparam logic [7:0] OFS_SMOOTH_CFG = 8'h10;
	localparam logic [7:0] OFS_MISC_CFG = 8'h11;
	localparam logic [7:0] OFS_READING_ONE = 8'h1a;
	localparam logic [7:0] OFS_READING_TWO = 8'h1b;
	localparam logic [7:0] OFS_READING_THREE = 8'h1c;
	localparam logic [7:0] OFS_READING_ZERO = 8'h33;

	// Reset values
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_READING = 8'h80;

	// Field positions, smoothing register
	localparam int BIT_SLOW_FIRST = 0;
	localparam int NUM_SLOW = 3;
	localparam int BIT_CORE_LOW = 6;
	localparam int BIT_EXTRA = 7;
	localparam logic [7:0] MASK_SMOOTH = 8'hc7;

	// Field positions, misc register
	localparam int BIT_HYST_OFF = 0;
	localparam int BIT_FORCE_FULL = 1;
	localparam int BIT_CPU_POWER = 2;
	localparam int BIT_SPINUP_STYLE = 3;
	localparam int BIT_BUS_TIMEOUT = 4;
	localparam logic [7:0] MASK_MISC = 8'h1f;
	localparam logic [7:0] MASK_MISC_UNLOCKED = 8'h02;

	// Smoothing scale factors: x4, then about +39.2 percent as 401/1024
	localparam int SLOW_SHIFT = 2;
	localparam int EXTRA_NUM = 401;
	localparam int EXTRA_SHIFT = 10;

	// Bus timeout
	localparam int CLK_HZ = 40000000;
	localparam int BUS_TIMEOUT_MS = 35;
	localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (CLK_HZ / 1000);

	// Register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Reading update from the link side
	typedef struct packed {
		logic [1:0] chan;
		logic [7:0] value;
	} reading_t;

	typedef enum logic [0:0] {
		CORE_NORMAL,
		CORE_ASLEEP
	} core_state_t;

endpackage

/* File: fan_monitor_config_regs.sv */
// Configuration and CPU thermal reading registers of the fan monitor.
// Assumes a register port on mclk (srst synchronous), CPU readings arriving on linkClk,
// and voltage, duty and bus state inputs from neighbouring logic on mclk.
`timescale 1ns/1ps

module fan_monitor_config_regs #(
	parameter int SMOOTH_W = 12,
	parameter int DUTY_W = 8,
	parameter int NUM_FANS = 3,
	parameter int TIMEOUT_CYC = fan_monitor_config_pkg::BUS_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Register port
	input fan_monitor_config_pkg::reg_req_t regReq,
	input wire logic lockSet,
	output logic [7:0] regRdata,
	output logic regRvalid,
	// Reading link
	input wire logic linkClk,
	input wire logic readingValid,
	input fan_monitor_config_pkg::reading_t readingIn,
	// Smoothing
	input wire logic [fan_monitor_config_pkg::NUM_SLOW*SMOOTH_W-1:0] smoothBase,
	output logic [fan_monitor_config_pkg::NUM_SLOW*(SMOOTH_W+3)-1:0] smoothEff,
	// Core voltage sleep
	input wire logic standbyPower,
	input wire logic coreVoltLow,
	input wire logic alertEnable,
	output logic coreLowStatusSet,
	output logic alertOutput,
	output logic cpuHotMonEn,
	output logic spinupStart,
	// Fan drive
	input wire logic [NUM_FANS*DUTY_W-1:0] autoDuty,
	input wire logic [NUM_FANS*DUTY_W-1:0] maxDuty,
	output logic [NUM_FANS*DUTY_W-1:0] fanDuty,
	output logic overtempHystEn,
	output logic spinupHoldHigh,
	output logic cpuPowerFlag,
	// Bus timeout
	input wire logic busInTransaction,
	input wire logic busActivity,
	output logic busRelease
);
	import fan_monitor_config_pkg::*;

	logic [7:0] smoothCfg_reg;
	logic [7:0] miscCfg_reg;
	logic [7:0] reading_reg [4];
	logic wrSmooth;
	logic wrMisc;

	assign wrSmooth = regReq.wr && regReq.addr == OFS_SMOOTH_CFG;
	assign wrMisc = regReq.wr && regReq.addr == OFS_MISC_CFG;

	// Configuration registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			smoothCfg_reg <= RST_CONFIG;
		end else if (wrSmooth && !lockSet) begin
			smoothCfg_reg <= regReq.wdata & MASK_SMOOTH;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			miscCfg_reg <= RST_CONFIG;
		end else if (wrMisc) begin
			if (lockSet) begin
				// Force-full stays writable under lock
				miscCfg_reg <= (miscCfg_reg & ~MASK_MISC_UNLOCKED) | (regReq.wdata & MASK_MISC_UNLOCKED);
			end else begin
				miscCfg_reg <= regReq.wdata & MASK_MISC;
			end
		end
	end

	// Read port: one cycle latency, unmapped offsets read zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			regRdata <= 8'h00;
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= regReq.rd;
			case (regReq.addr)
				OFS_SMOOTH_CFG: regRdata <= smoothCfg_reg;
				OFS_MISC_CFG: regRdata <= miscCfg_reg;
				OFS_READING_ZERO: regRdata <= reading_reg[0];
				OFS_READING_ONE: regRdata <= reading_reg[1];
				OFS_READING_TWO: regRdata <= reading_reg[2];
				OFS_READING_THREE: regRdata <= reading_reg[3];
				default: regRdata <= 8'h00;
			endcase
		end
	end

	// Link side: hold the word and flip a toggle; srst reaches it through a synchroniser
	logic [1:0] linkRstSync;
	logic linkToggle_reg;
	reading_t linkHold_reg;

	always_ff @(posedge linkClk) begin
		linkRstSync <= {linkRstSync[0], srst};
	end

	always_ff @(posedge linkClk) begin
		if (linkRstSync[1]) begin
			linkToggle_reg <= 1'b0;
			linkHold_reg <= '0;
		end else if (readingValid) begin
			linkToggle_reg <= ~linkToggle_reg;
			linkHold_reg <= readingIn;
		end
	end

	// Clock side: toggle synchroniser, hold word is stable when the edge is seen
	logic [2:0] toggleSync;
	logic readingStrobe;

	always_ff @(posedge mclk) begin
		if (srst) begin
			toggleSync <= 3'h0;
		end else begin
			toggleSync <= {toggleSync[1:0], linkToggle_reg};
		end
	end

	assign readingStrobe = toggleSync[2] ^ toggleSync[1];

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_reading
			always_ff @(posedge mclk) begin
				if (srst) begin
					reading_reg[ch] <= RST_READING;
				end else if (readingStrobe && linkHold_reg.chan == 2'(ch)) begin
					reading_reg[ch] <= linkHold_reg.value;
				end
			end
		end
	endgenerate

	// Effective smoothing times per channel
	generate
		for (ch = 0; ch < NUM_SLOW; ch++) begin : g_smooth
			logic [SMOOTH_W+2:0] scaled;
			logic [SMOOTH_W+2+EXTRA_SHIFT:0] extraProd;
			logic [SMOOTH_W+2:0] extraAdd;
			assign scaled = smoothCfg_reg[BIT_SLOW_FIRST+ch]
				? {1'b0, smoothBase[ch*SMOOTH_W +: SMOOTH_W], 2'b00}
				: {3'b000, smoothBase[ch*SMOOTH_W +: SMOOTH_W]};
			assign extraProd = (SMOOTH_W+3+EXTRA_SHIFT)'(scaled) * (SMOOTH_W+3+EXTRA_SHIFT)'(EXTRA_NUM);
			assign extraAdd = extraProd[EXTRA_SHIFT +: SMOOTH_W+3];
			always_ff @(posedge mclk) begin
				if (srst) begin
					smoothEff[ch*(SMOOTH_W+3) +: SMOOTH_W+3] <= '0;
				end else begin
					smoothEff[ch*(SMOOTH_W+3) +: SMOOTH_W+3] <=
						smoothCfg_reg[BIT_EXTRA] ? scaled + extraAdd : scaled;
				end
			end
		end
	endgenerate

	// Core voltage low sleep
	logic [1:0] standbySync;
	core_state_t coreState_reg;
	core_state_t coreState_next;

	always_ff @(posedge mclk) begin
		if (srst) begin
			standbySync <= 2'b00;
		end else begin
			standbySync <= {standbySync[0], standbyPower};
		end
	end

	always_comb begin
		coreState_next = coreState_reg;
		case (coreState_reg)
			CORE_NORMAL: begin
				if (smoothCfg_reg[BIT_CORE_LOW] && standbySync[1] && coreVoltLow) begin
					coreState_next = CORE_ASLEEP;
				end
			end
			CORE_ASLEEP: begin
				if (!coreVoltLow) begin
					coreState_next = CORE_NORMAL;
				end
			end
			default: coreState_next = CORE_NORMAL;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			coreState_reg <= CORE_NORMAL;
			coreLowStatusSet <= 1'b0;
			alertOutput <= 1'b0;
			spinupStart <= 1'b0;
		end else begin
			coreState_reg <= coreState_next;
			coreLowStatusSet <= coreState_reg == CORE_NORMAL && coreState_next == CORE_ASLEEP;
			alertOutput <= coreState_reg == CORE_NORMAL && coreState_next == CORE_ASLEEP && alertEnable;
			spinupStart <= coreState_reg == CORE_ASLEEP && coreState_next == CORE_NORMAL;
		end
	end

	assign cpuHotMonEn = coreState_reg == CORE_NORMAL;

	// Fan duty selection
	generate
		for (ch = 0; ch < NUM_FANS; ch++) begin : g_fan
			always_ff @(posedge mclk) begin
				if (srst) begin
					fanDuty[ch*DUTY_W +: DUTY_W] <= '0;
				end else begin
					fanDuty[ch*DUTY_W +: DUTY_W] <= miscCfg_reg[BIT_FORCE_FULL]
						? maxDuty[ch*DUTY_W +: DUTY_W] : autoDuty[ch*DUTY_W +: DUTY_W];
				end
			end
		end
	endgenerate

	assign overtempHystEn = ~miscCfg_reg[BIT_HYST_OFF];
	assign spinupHoldHigh = miscCfg_reg[BIT_SPINUP_STYLE];
	assign cpuPowerFlag = miscCfg_reg[BIT_CPU_POWER];

	// Bus timeout: armed while the control bit is 0
	logic [$clog2(TIMEOUT_CYC+1)-1:0] idleCnt_reg;
	logic timeoutArmed;

	assign timeoutArmed = ~miscCfg_reg[BIT_BUS_TIMEOUT];

	always_ff @(posedge mclk) begin
		if (srst) begin
			idleCnt_reg <= '0;
			busRelease <= 1'b0;
		end else begin
			busRelease <= 1'b0;
			if (!busInTransaction || busActivity || !timeoutArmed) begin
				idleCnt_reg <= '0;
			end else if (idleCnt_reg == ($clog2(TIMEOUT_CYC+1))'(TIMEOUT_CYC)) begin
				idleCnt_reg <= '0;
				busRelease <= 1'b1;
			end else begin
				idleCnt_reg <= idleCnt_reg + 1'b1;
			end
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_lock_holds_smooth: assert property (lockSet && wrSmooth |=> $stable(smoothCfg_reg))
		else $error("smoothing config changed under lock");
	a_force_unlocked: assert property (wrMisc |=> miscCfg_reg[BIT_FORCE_FULL] == $past(regReq.wdata[BIT_FORCE_FULL]))
		else $error("force-full write lost");
	a_misc_reserved_zero: assert property (miscCfg_reg[7:5] == 3'b000)
		else $error("reserved misc bits set");
	a_force_duty: assert property (miscCfg_reg[BIT_FORCE_FULL] |=> fanDuty == $past(maxDuty))
		else $error("forced duty not at max");
	a_sleep_entry: assert property (coreState_reg == CORE_NORMAL && smoothCfg_reg[BIT_CORE_LOW]
		&& standbySync[1] && coreVoltLow |=> coreLowStatusSet && !cpuHotMonEn)
		else $error("core-low sleep not entered");
	a_wake_spinup: assert property (coreState_reg == CORE_ASLEEP && !coreVoltLow |=> spinupStart && cpuHotMonEn)
		else $error("wake without spin-up");
	a_spinup_once: assert property (spinupStart |=> !spinupStart)
		else $error("spin-up pulse too long");
	a_hyst_polarity: assert property (wrMisc && !lockSet
		|=> overtempHystEn == !$past(regReq.wdata[BIT_HYST_OFF]))
		else $error("hysteresis polarity wrong");
	a_reading_read: assert property (regReq.rd && regReq.addr == OFS_READING_ZERO |=> regRvalid
		&& regRdata == $past(reading_reg[0]))
		else $error("reading zero read wrong");
	a_reading_reset: assert property ($fell(srst) |-> reading_reg[1] == RST_READING)
		else $error("reading not reset");
	a_timeout_only_idle: assert property (busRelease |-> $past(busInTransaction) && !$past(busActivity))
		else $error("release while active");
	a_slow_scale: assert property (smoothCfg_reg[0] && !smoothCfg_reg[BIT_EXTRA]
		|=> smoothEff[SMOOTH_W+2:0] == {1'b0, $past(smoothBase[SMOOTH_W-1:0]), 2'b00})
		else $error("slow scale wrong");

	c_sleep_wake: cover property (coreState_reg == CORE_ASLEEP ##[1:20] spinupStart);
	c_reading_update: cover property (readingStrobe);
	c_locked_force: cover property (lockSet && wrMisc);
	c_bus_release: cover property (busRelease);

endmodule // fan_monitor_config_regs

/* File: reading_link_model.sv */
// Far-side model of the CPU reading link: sends one reading per toggle of go.
// Assumes the bench keeps at least four link clocks between requests.
`timescale 1ns/1ps
module reading_link_model
	import fan_monitor_config_pkg::*;
(
	// Link clock and bench command
	input wire logic linkClk,
	input wire logic go,
	input wire logic [1:0] chan,
	input wire logic [7:0] value,
	// Link outputs
	output logic readingValid,
	output fan_monitor_config_pkg::reading_t readingIn
);
	logic goSeen = 1'b0;
	logic validReg = 1'b0;
	reading_t dataReg = '0;
	assign readingValid = validReg;
	assign readingIn = dataReg;
	always @(posedge linkClk) begin
		if (go !== goSeen) begin
			goSeen <= go;
			validReg <= 1'b1;
			dataReg <= '{chan: chan, value: value};
		end else begin
			validReg <= 1'b0;
			// Data alternates between the inverse of the last value and the last value once the pulse is over
			dataReg <= ~dataReg;
		end
	end
endmodule // reading_link_model

/* File: fan_monitor_config_regs_tb_top.sv */
// Self-checking bench for the fan monitor configuration registers.
// Assumes 25 ns mclk, 30 ns link clock and a shortened bus timeout.
`timescale 1ns/1ps
module fan_monitor_config_regs_tb_top;
	import fan_monitor_config_pkg::*;
	localparam int TO = 20;
	logic mclk = 0, srst = 1, linkClk = 0, lockSet = 0, regRvalid, readingValid, go = 0;
	logic standbyPower = 0, coreVoltLow = 0, alertEnable = 0, busInTransaction = 0, busActivity = 0;
	logic coreLowStatusSet, alertOutput, cpuHotMonEn, spinupStart, overtempHystEn, spinupHoldHigh;
	logic cpuPowerFlag, busRelease;
	logic [7:0] regRdata, lval = 0;
	logic [1:0] lchan = 0;
	logic [35:0] smoothBase = '0;
	logic [44:0] smoothEff;
	logic [23:0] autoDuty = '0, maxDuty = '0, fanDuty;
	reg_req_t regReq = '0;
	reading_t readingIn;
	int seed = 79, failCount = 0, nChecks = 0, smoothM = 0, miscM = 0, i, n;
	int rdM[4] = '{default: 128};
	logic [7:0] ofs[7] = '{8'h10, 8'h11, 8'h1a, 8'h1b, 8'h1c, 8'h33, 8'h12};

	initial forever #12.5 mclk = ~mclk;
	initial begin
		#7;
		forever #15 linkClk = ~linkClk;
	end

	fan_monitor_config_regs #(.TIMEOUT_CYC(TO)) DUT (.mclk(mclk), .srst(srst), .regReq(regReq),
		.lockSet(lockSet), .regRdata(regRdata), .regRvalid(regRvalid), .linkClk(linkClk),
		.readingValid(readingValid), .readingIn(readingIn), .smoothBase(smoothBase), .smoothEff(smoothEff),
		.standbyPower(standbyPower), .coreVoltLow(coreVoltLow), .alertEnable(alertEnable),
		.coreLowStatusSet(coreLowStatusSet), .alertOutput(alertOutput), .cpuHotMonEn(cpuHotMonEn),
		.spinupStart(spinupStart), .autoDuty(autoDuty), .maxDuty(maxDuty), .fanDuty(fanDuty),
		.overtempHystEn(overtempHystEn), .spinupHoldHigh(spinupHoldHigh), .cpuPowerFlag(cpuPowerFlag),
		.busInTransaction(busInTransaction), .busActivity(busActivity), .busRelease(busRelease));

	reading_link_model LINK (.linkClk(linkClk), .go(go), .chan(lchan), .value(lval),
		.readingValid(readingValid), .readingIn(readingIn));

	task automatic printVerdict;
		if (failCount == 0 && nChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [7:0] mexp(input logic [7:0] a);
		case (a)
			8'h10: return 8'(smoothM) & 8'hc7;
			8'h11: return 8'(miscM) & 8'h1f;
			8'h1a: return 8'(rdM[1]);
			8'h1b: return 8'(rdM[2]);
			8'h1c: return 8'(rdM[3]);
			8'h33: return 8'(rdM[0]);
			default: return 8'h00;
		endcase
	endfunction

	function automatic int seff(input int b, input int ch);
		int t;
		t = smoothM[ch] ? b * 4 : b;
		return smoothM[7] ? t + (t * 401) / 1024 : t;
	endfunction

	task automatic mwr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk) regReq.wr <= 1'b0;
		if (a == 8'h10 && !lockSet)
			smoothM = d;
		if (a == 8'h11)
			miscM = lockSet ? (miscM & 8'hfd) | (d & 8'h02) : d;
	endtask

	task automatic chkAll;
		foreach (ofs[k]) begin
			@(posedge mclk) regReq <= '{wr: 1'b0, rd: 1'b1, addr: ofs[k], wdata: 8'h00};
			@(posedge mclk) regReq.rd <= 1'b0;
			#1 chk("valid", regRvalid, 1);
			chk($sformatf("reg %h", ofs[k]), regRdata, mexp(ofs[k]));
		end
	endtask

	task automatic waitFor(ref logic s, input int lim, output int c);
		c = 0;
		do begin
			@(posedge mclk) #1 c++;
		end while (s !== 1'b1 && c < lim);
		if (s !== 1'b1) begin
			failCount++;
			printVerdict;
		end
	endtask

	task automatic quiet(input logic act);
		for (n = 0; n < 60; n++) begin
			@(posedge mclk) busActivity <= act && (n % 8 == 0);
			#1 chk("no release", busRelease, 0);
		end
	endtask

	initial begin
		repeat (90000) @(posedge mclk);
		failCount++;
		printVerdict;
	end

	initial begin
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		#1 chk("hyst", overtempHystEn, 1);
		chk("hotmon", cpuHotMonEn, 1);
		chkAll;
		for (i = 0; i < 8; i++) begin
			mwr(8'h10, 8'($random(seed)));
			mwr(8'h11, 8'($random(seed)) & 8'h1f);
			smoothBase <= 36'($random(seed));
			autoDuty <= 24'($random(seed));
			maxDuty <= 24'($random(seed));
			mwr(8'h33, 8'($random(seed)));
			@(posedge mclk) #1 chk("hyst", overtempHystEn, !miscM[0]);
			chk("force", fanDuty, miscM[1] ? maxDuty : autoDuty);
			chk("spin", spinupHoldHigh, miscM[3]);
			chk("cpuw", cpuPowerFlag, miscM[2]);
			for (n = 0; n < 3; n++)
				chk("smooth", smoothEff[n*15+:15], seff(smoothBase[n*12+:12], n));
			chkAll;
		end
		@(posedge mclk) lockSet <= 1'b1;
		mwr(8'h10, ~8'(smoothM));
		mwr(8'h11, ~8'(miscM) & 8'h1f);
		chkAll;
		@(posedge mclk) lockSet <= 1'b0;
		for (i = 0; i < 4; i++) begin
			@(posedge mclk) lchan <= 2'(i);
			lval <= 8'($random(seed));
			go <= ~go;
			repeat (14) @(posedge mclk);
			rdM[i] = lval;
		end
		chkAll;
		mwr(8'h10, 8'h40);
		standbyPower <= 1'b1;
		alertEnable <= 1'b1;
		coreVoltLow <= 1'b1;
		waitFor(coreLowStatusSet, 12, n);
		chk("alert", alertOutput, 1);
		chk("hotmon", cpuHotMonEn, 0);
		@(posedge mclk) coreVoltLow <= 1'b0;
		waitFor(spinupStart, 12, n);
		chk("hotmon", cpuHotMonEn, 1);
		// Second sleep with the alert masked
		@(posedge mclk) alertEnable <= 1'b0;
		coreVoltLow <= 1'b1;
		waitFor(coreLowStatusSet, 12, n);
		chk("alert", alertOutput, 0);
		chk("hotmon", cpuHotMonEn, 0);
		@(posedge mclk) coreVoltLow <= 1'b0;
		waitFor(spinupStart, 12, n);
		chk("hotmon", cpuHotMonEn, 1);
		mwr(8'h11, 8'h00);
		busInTransaction <= 1'b1;
		quiet(1'b1);
		waitFor(busRelease, 40, n);
		chk("timeout", n inside {[TO - 8 : TO + 4]}, 1);
		mwr(8'h11, 8'h10);
		quiet(1'b0);
		printVerdict;
	end
endmodule // fan_monitor_config_regs_tb_top
